// file: verilog/dsg_pkg.sv
package dsg_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] DSG_SOFT_RESET_CTRL_0_OFF = 12'h040;
  localparam logic [11:0] DSG_RUN_CLOCK_CONFIG_OFF = 12'h060;
  localparam logic [11:0] DSG_RUN_PORT_CLOCK_GATE_OFF = 12'h108;
  localparam logic [11:0] DSG_SLEEP_PORT_CLOCK_GATE_OFF = 12'h118;
  localparam logic [11:0] DSG_DEEP_SLEEP_PORT_CLOCK_GATE_OFF = 12'h128;
  localparam logic [11:0] DSG_IRQ_STATUS_OFF = 12'h150;
  localparam logic [11:0] DSG_IRQ_MASK_OFF = 12'h154;
  localparam logic [11:0] DSG_MODE_STATUS_OFF = 12'h158;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int DSG_PORT_BITS = 5;
  localparam int DSG_PWM_RESET_BIT = 20;
  localparam int DSG_WATCHDOG_RESET_BIT = 3;
  localparam int DSG_AUTO_CLOCK_GATING_BIT = 0;
  localparam int DSG_IRQ_BITS = 4;
  localparam int DSG_IRQ_FAULT_BIT = 0;
  localparam int DSG_IRQ_DEEP_BIT = 1;
  localparam int DSG_IRQ_SLEEP_BIT = 2;
  localparam int DSG_IRQ_WAKE_BIT = 3;
  localparam int DSG_MODE_FIELD_LSB = 8;

  // ----------------------------------------
  // reset values and writable mask
  // ----------------------------------------
  localparam logic [31:0] DSG_SOFT_RESET_CTRL_0_RST = 32'h0000_0000;
  localparam logic [4:0] DSG_PORT_GATE_RST = 5'h00;
  localparam logic [3:0] DSG_IRQ_RST = 4'h0;
  localparam logic [31:0] DSG_WRITABLE_SRC0 = 32'h0010_0008;

  // ----------------------------------------
  // bus encodings
  // ----------------------------------------
  localparam logic [2:0] DSG_HSIZE_WORD = 3'h2;
  localparam logic [1:0] DSG_HRESP_OKAY = 2'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_t;

  typedef struct packed {
    logic [4:0] run;
    logic [4:0] sleep;
    logic [4:0] deep;
  } dsg_gate_set_t;

  typedef struct packed {
    logic valid;
    logic [2:0] port;
  } dsg_unit_req_t;

  function automatic logic dsg_hit(input logic [11:0] addr, input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction

endpackage

// file: verilog/dsg_gate_sel.sv
`timescale 1ns/1ps
module dsg_gate_sel (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // gating sources
  input wire dsg_pkg::dsg_gate_set_t gates,
  input wire logic auto_gate,
  input wire dsg_pkg::dsg_mode_t mode,
  // unit access check
  input wire dsg_pkg::dsg_unit_req_t unit_req,
  output logic unit_fault,
  output logic unit_grant,
  // clock enables
  output logic [4:0] port_clk_en
);
  import dsg_pkg::*;

  logic [4:0] sel_next;
  logic en_bit;

  // ----------------------------------------
  // pick source by power mode
  // ----------------------------------------
  always_comb begin
    sel_next = gates.run;
    if (auto_gate) begin
      case (mode)
        DSG_MODE_RUN: sel_next = gates.run;
        DSG_MODE_SLEEP: sel_next = gates.sleep;
        DSG_MODE_DEEP: sel_next = gates.deep;
        default: sel_next = gates.run;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_clk_en <= DSG_PORT_GATE_RST;
    end else begin
      port_clk_en <= sel_next;
    end
  end

  // ----------------------------------------
  // unit access check
  // ----------------------------------------
  assign en_bit = (unit_req.port < 3'(DSG_PORT_BITS)) ? port_clk_en[unit_req.port] : 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_fault <= 1'b0;
      unit_grant <= 1'b0;
    end else begin
      unit_fault <= unit_req.valid && !en_bit;
      unit_grant <= unit_req.valid && en_bit;
    end
  end

endmodule // dsg_gate_sel

// file: verilog/dsg_top.sv
// What this block does
// - set gating bit clocks unit, clear stops it
// - access to gated unit raises unit_fault, bus answer stays okay
// - deep-sleep gating bits reset to zero
// - gating source follows run, sleep, deep sleep
// - sleep and deep-sleep gating only with auto gating set
// - deep-sleep bits 4:0 enable ports E..A
// - gating bits 31:5 read zero, read-only
// - reset-control writes masked by capability bits
// - bit 20 resets pulse-width modulator
// - bit 3 resets watchdog
// - reset control zero at reset, others zero
`timescale 1ns/1ps
module dsg_top #(
  parameter int NUM_PORTS = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // power mode requests
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // capability bits
  input wire logic [31:0] capability_mask_1,
  // access to gated units
  input wire dsg_pkg::dsg_unit_req_t unit_req,
  output logic unit_fault,
  output logic unit_grant,
  // unit controls
  output logic [4:0] port_clk_en,
  output logic pwm_reset,
  output logic watchdog_reset,
  output dsg_pkg::dsg_mode_t power_mode,
  // interrupt
  output logic irq
);
  import dsg_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (NUM_PORTS < 1 || NUM_PORTS > DSG_PORT_BITS) begin : g_bad_ports
    $error("dsg_top: NUM_PORTS must lie in 1..5");
  end

  localparam logic [4:0] PORT_MASK = 5'((1 << NUM_PORTS) - 1);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic addr_ok;
  logic wr_take;
  logic rd_take;
  logic wr_now;
  logic [31:0] src0_reg;
  logic [31:0] src0_next;
  logic [4:0] run_gate_reg;
  logic [4:0] run_gate_next;
  logic [4:0] sleep_gate_reg;
  logic [4:0] sleep_gate_next;
  logic [4:0] deep_gate_reg;
  logic [4:0] deep_gate_next;
  logic auto_gate_reg;
  logic auto_gate_next;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_stat_next;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_mask_next;
  logic [3:0] irq_event;
  logic [31:0] rd_next;
  logic [31:0] hrdata_reg;
  dsg_mode_t mode_reg;
  dsg_mode_t mode_next;
  dsg_gate_set_t gates;
  logic fault_int;

  // ----------------------------------------
  // bus address phase
  // ----------------------------------------
  assign addr_ok = hsel && htrans[1] && hready && (hsize == DSG_HSIZE_WORD);
  assign wr_take = addr_ok && hwrite;
  assign rd_take = addr_ok && !hwrite;
  assign wr_now = wr_pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= haddr[11:0];
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = DSG_HRESP_OKAY;

  // ----------------------------------------
  // register next values
  // ----------------------------------------
  always_comb begin
    src0_next = src0_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_SOFT_RESET_CTRL_0_OFF)) begin
      src0_next = hwdata & capability_mask_1 & DSG_WRITABLE_SRC0;
    end
  end

  always_comb begin
    deep_gate_next = deep_gate_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_DEEP_SLEEP_PORT_CLOCK_GATE_OFF)) begin
      deep_gate_next = hwdata[4:0] & PORT_MASK;
    end
  end

  always_comb begin
    run_gate_next = run_gate_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_RUN_PORT_CLOCK_GATE_OFF)) begin
      run_gate_next = hwdata[4:0] & PORT_MASK;
    end
  end

  always_comb begin
    sleep_gate_next = sleep_gate_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_SLEEP_PORT_CLOCK_GATE_OFF)) begin
      sleep_gate_next = hwdata[4:0] & PORT_MASK;
    end
  end

  always_comb begin
    auto_gate_next = auto_gate_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_RUN_CLOCK_CONFIG_OFF)) begin
      auto_gate_next = hwdata[DSG_AUTO_CLOCK_GATING_BIT];
    end
  end

  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_IRQ_MASK_OFF)) begin
      irq_mask_next = hwdata[3:0];
    end
  end

  // write one clears; a new event wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_now && dsg_hit(wr_addr_reg, DSG_IRQ_STATUS_OFF)) begin
      irq_stat_next = irq_stat_reg & ~hwdata[3:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src0_reg <= DSG_SOFT_RESET_CTRL_0_RST;
    end else begin
      src0_reg <= src0_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deep_gate_reg <= DSG_PORT_GATE_RST;
      run_gate_reg <= DSG_PORT_GATE_RST;
      sleep_gate_reg <= DSG_PORT_GATE_RST;
      auto_gate_reg <= 1'b0;
    end else begin
      deep_gate_reg <= deep_gate_next;
      run_gate_reg <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      auto_gate_reg <= auto_gate_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= DSG_IRQ_RST;
      irq_mask_reg <= DSG_IRQ_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ----------------------------------------
  // read data, forwarded from next values; mode status from current state
  // ----------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000;
    if (dsg_hit(haddr[11:0], DSG_SOFT_RESET_CTRL_0_OFF)) begin
      rd_next = src0_next;
    end else if (dsg_hit(haddr[11:0], DSG_DEEP_SLEEP_PORT_CLOCK_GATE_OFF)) begin
      rd_next = {27'h0000000, deep_gate_next};
    end else if (dsg_hit(haddr[11:0], DSG_RUN_PORT_CLOCK_GATE_OFF)) begin
      rd_next = {27'h0000000, run_gate_next};
    end else if (dsg_hit(haddr[11:0], DSG_SLEEP_PORT_CLOCK_GATE_OFF)) begin
      rd_next = {27'h0000000, sleep_gate_next};
    end else if (dsg_hit(haddr[11:0], DSG_RUN_CLOCK_CONFIG_OFF)) begin
      rd_next[DSG_AUTO_CLOCK_GATING_BIT] = auto_gate_next;
    end else if (dsg_hit(haddr[11:0], DSG_IRQ_STATUS_OFF)) begin
      rd_next = {28'h0000000, irq_stat_next};
    end else if (dsg_hit(haddr[11:0], DSG_IRQ_MASK_OFF)) begin
      rd_next = {28'h0000000, irq_mask_next};
    end else if (dsg_hit(haddr[11:0], DSG_MODE_STATUS_OFF)) begin
      rd_next = {22'h000000, mode_reg, 3'h0, port_clk_en};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= rd_next;
    end
  end

  assign hrdata = hrdata_reg;

  // ----------------------------------------
  // power mode tracker
  // ----------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      DSG_MODE_RUN: begin
        if (deep_sleep_req) begin
          mode_next = DSG_MODE_DEEP;
        end else if (sleep_req) begin
          mode_next = DSG_MODE_SLEEP;
        end
      end
      DSG_MODE_SLEEP: begin
        if (deep_sleep_req) begin
          mode_next = DSG_MODE_DEEP;
        end else if (!sleep_req) begin
          mode_next = DSG_MODE_RUN;
        end
      end
      DSG_MODE_DEEP: begin
        if (!deep_sleep_req) begin
          mode_next = sleep_req ? DSG_MODE_SLEEP : DSG_MODE_RUN;
        end
      end
      default: mode_next = DSG_MODE_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= DSG_MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign power_mode = mode_reg;

  // ----------------------------------------
  // gating and access check
  // ----------------------------------------
  assign gates = '{run: run_gate_reg, sleep: sleep_gate_reg, deep: deep_gate_reg};

  dsg_gate_sel u_gate_sel (
    .hclk(hclk),
    .hresetn(hresetn),
    .gates(gates),
    .auto_gate(auto_gate_reg),
    .mode(mode_reg),
    .unit_req(unit_req),
    .unit_fault(fault_int),
    .unit_grant(unit_grant),
    .port_clk_en(port_clk_en)
  );

  assign unit_fault = fault_int;

  // ----------------------------------------
  // software resets
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_reset <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      pwm_reset <= src0_next[DSG_PWM_RESET_BIT];
      watchdog_reset <= src0_next[DSG_WATCHDOG_RESET_BIT];
    end
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  always_comb begin
    irq_event = 4'h0;
    irq_event[DSG_IRQ_FAULT_BIT] = fault_int;
    irq_event[DSG_IRQ_DEEP_BIT] = (mode_next == DSG_MODE_DEEP) && (mode_reg != DSG_MODE_DEEP);
    irq_event[DSG_IRQ_SLEEP_BIT] = (mode_next == DSG_MODE_SLEEP) && (mode_reg != DSG_MODE_SLEEP);
    irq_event[DSG_IRQ_WAKE_BIT] = (mode_next == DSG_MODE_RUN) && (mode_reg != DSG_MODE_RUN);
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // dsg_top

// file: verif/dsg_top_asserts.sv
`timescale 1ns/1ps
module dsg_top_asserts
  import dsg_pkg::*;
#(
  parameter int NUM_PORTS = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // control inputs
  input wire logic deep_sleep_req,
  input wire logic [31:0] capability_mask_1,
  input wire dsg_pkg::dsg_unit_req_t unit_req,
  // observed outputs
  input wire logic unit_fault,
  input wire logic unit_grant,
  input wire logic [4:0] port_clk_en,
  input wire logic pwm_reset,
  input wire logic watchdog_reset,
  input wire dsg_pkg::dsg_mode_t power_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_src;
  logic on;
  assign wr_src = hsel && htrans[1] && hready && hwrite && hsize == DSG_HSIZE_WORD
    && haddr[11:2] == 10'h010;
  assign on = unit_req.port < NUM_PORTS && port_clk_en[unit_req.port];

  a_fault_gated: assert property (unit_req.valid && !on |=> unit_fault)
    else $error("access to unclocked port not faulted");
  a_grant_clocked: assert property (unit_req.valid && on |=> unit_grant && !unit_fault)
    else $error("access to clocked port not granted");
  a_one_answer: assert property (!(unit_fault && unit_grant))
    else $error("fault and grant together");
  a_quiet_idle: assert property (!unit_req.valid |=> !unit_fault && !unit_grant)
    else $error("answer without access");
  a_pwm_write: assert property (wr_src ##1 capability_mask_1[20] |=>
    pwm_reset == $past(hwdata[20])) else $error("pwm reset bit not written");
  a_pwm_masked: assert property (wr_src ##1 !capability_mask_1[20] && !pwm_reset
    |=> !pwm_reset) else $error("masked pwm reset bit set");
  a_wdog_write: assert property (wr_src ##1 capability_mask_1[3] |=>
    watchdog_reset == $past(hwdata[3])) else $error("watchdog reset bit not written");
  a_reset_clear: assert property ($rose(hresetn) |-> port_clk_en == 5'h00
    && !pwm_reset && !watchdog_reset) else $error("outputs not clear after reset");
  a_mode_deep: assert property (deep_sleep_req |=> power_mode == DSG_MODE_DEEP)
    else $error("deep sleep request not followed");
endmodule // dsg_top_asserts

bind dsg_top dsg_top_asserts #(.NUM_PORTS(NUM_PORTS)) dsg_top_asserts_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .deep_sleep_req(deep_sleep_req), .capability_mask_1(capability_mask_1),
  .unit_req(unit_req), .unit_fault(unit_fault), .unit_grant(unit_grant),
  .port_clk_en(port_clk_en), .pwm_reset(pwm_reset), .watchdog_reset(watchdog_reset),
  .power_mode(power_mode));

// file: verif/dsg_core_model.sv
`timescale 1ns/1ps
module dsg_core_model (
  // bus answer
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // wait bound used up
  output logic hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  task automatic wait_ready;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 16) begin
      @(posedge hclk);
      n++;
    end
    if (n == 16) hung = 1'b1;
  endtask
  // one single word transfer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    wait_ready();
    q = hrdata;
  endtask
endmodule // dsg_core_model

// file: verif/dsg_top_tb.sv
`timescale 1ns/1ps
module dsg_top_tb;
  import dsg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, sleep_req, deep_sleep_req, hung;
  logic unit_fault, unit_grant, pwm_reset, watchdog_reset, irq;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, capability_mask_1, q, d, x, cap;
  logic [4:0] port_clk_en, r, s, dd, e;
  dsg_unit_req_t unit_req;
  dsg_mode_t power_mode;
  int n_fail, compares, seed;

  dsg_top dsg_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .capability_mask_1(capability_mask_1),
    .unit_req(unit_req), .unit_fault(unit_fault), .unit_grant(unit_grant),
    .port_clk_en(port_clk_en), .pwm_reset(pwm_reset), .watchdog_reset(watchdog_reset),
    .power_mode(power_mode), .irq(irq)
  );
  dsg_core_model dsg_core_model_inst (
    .hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    dsg_core_model_inst.xfer(w, a, v, q);
    if (hung) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
    chk(hresp, DSG_HRESP_OKAY);
  endtask
  task automatic unit_pulse(input logic [2:0] p);
    @(posedge hclk);
    unit_req <= {1'b1, p};
    @(posedge hclk);
    unit_req.valid <= 1'b0;
    @(negedge hclk);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge hclk);
    chk(irq, exp);
    @(posedge hclk);
  endtask
  task automatic mode_chk(input logic sl, input logic dp, input logic au, input dsg_mode_t m);
    sleep_req <= sl;
    deep_sleep_req <= dp;
    repeat (3) @(posedge hclk);
    e = (!au || m == DSG_MODE_RUN) ? r : (m == DSG_MODE_SLEEP ? s : dd);
    chk(power_mode, m);
    chk(port_clk_en, e);
    rd_chk(12'h158, {22'h0, m, 3'h0, e});
    for (int p = 0; p < 8; p++) begin
      unit_pulse(p[2:0]);
      chk({unit_grant, unit_fault}, (p < 5 && e[p]) ? 32'h2 : 32'h1);
    end
    @(posedge hclk);
    $display("test mode %0d auto %0d done", m, au);
  endtask

  // ----------------------------------------
  // clock and sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    sleep_req = 1'b0;
    deep_sleep_req = 1'b0;
    capability_mask_1 = 32'hFFFF_FFFF;
    unit_req = '0;
    n_fail = 0;
    compares = 0;
    seed = 47834;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(12'h040, 32'h0);
    rd_chk(12'h128, 32'h0);
    chk(port_clk_en, 32'h0);
    rd_chk(12'h200, 32'h0);
    $display("test reset values done");
    repeat (6) begin
      d = $random(seed);
      bus(1'b1, 12'h128, d);
      rd_chk(12'h128, d & 32'h1F);
    end
    bus(1'b1, 12'h128, (q & ~32'h1F) | 32'h15);
    rd_chk(12'h128, 32'h15);
    $display("test gating fields done");
    repeat (8) begin
      cap = $random(seed);
      d = $random(seed);
      capability_mask_1 <= 32'hFFFF_FFFF;
      bus(1'b1, 12'h040, 32'h0);
      capability_mask_1 <= cap;
      bus(1'b1, 12'h040, d);
      x = d & cap & 32'h0010_0008;
      rd_chk(12'h040, x);
      chk({pwm_reset, watchdog_reset}, {x[20], x[3]});
    end
    $display("test soft reset done");
    r = 5'($random(seed));
    s = 5'($random(seed));
    dd = 5'($random(seed));
    bus(1'b1, 12'h108, {27'h0, r});
    bus(1'b1, 12'h118, {27'h0, s});
    bus(1'b1, 12'h128, {27'h0, dd});
    mode_chk(1'b0, 1'b0, 1'b0, DSG_MODE_RUN);
    mode_chk(1'b0, 1'b1, 1'b0, DSG_MODE_DEEP);
    bus(1'b1, 12'h060, 32'h1);
    rd_chk(12'h060, 32'h1);
    mode_chk(1'b1, 1'b0, 1'b1, DSG_MODE_SLEEP);
    mode_chk(1'b1, 1'b1, 1'b1, DSG_MODE_DEEP);
    mode_chk(1'b0, 1'b0, 1'b1, DSG_MODE_RUN);
    rd_chk(12'h150, 32'hF);
    bus(1'b1, 12'h150, 32'hF);
    rd_chk(12'h150, 32'h0);
    bus(1'b1, 12'h154, 32'h1);
    rd_chk(12'h154, 32'h1);
    irq_chk(1'b0);
    unit_pulse(3'h7);
    irq_chk(1'b1);
    bus(1'b1, 12'h154, 32'h0);
    irq_chk(1'b0);
    bus(1'b1, 12'h154, 32'h1);
    irq_chk(1'b1);
    bus(1'b1, 12'h150, 32'h1);
    irq_chk(1'b0);
    $display("test interrupt done");
    capability_mask_1 <= 32'hFFFF_FFFF;
    bus(1'b1, 12'h040, 32'h0010_0008);
    bus(1'b1, 12'h128, 32'h1F);
    chk({pwm_reset, watchdog_reset}, 32'h3);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(port_clk_en, 32'h0);
    chk({pwm_reset, watchdog_reset}, 32'h0);
    rd_chk(12'h040, 32'h0);
    rd_chk(12'h128, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // dsg_top_tb
